// >>> logic/fsk4_cfg.svh
// Constants of the formatted frame codec: offsets, fields, resets.
// Assumes inclusion by bare name from the codec's design files.
// Operation
// - Receive mode starts sync hunt, raises sync interrupt
// - Bad first control blocks: keep scanning frames
// - Accept all-zero code or one of six
// - Failed match, closed receive: reject, hunt again
// - Accept raises called, reports code and match
// - Soft mode sends log-likelihood values, faster service
// - Failed check: event with data ready, status
// - End, drop or idle ends call, hunt
// - Consecutive corrupt superframes reaching threshold drop call
// - Open receive delivers all data regardless
// - Frame: sync, radio info, slow control blocks
// - Sync-burst frame: parameter block and padding
// - Service frame: two traffic blocks, no mixing
// - Second protocol: code match plus type mask
// - Transmit codes blocks, inserts preamble and sync
// - Channel bit picks frame, mode picks coding
// - Sync-burst sends stored call sign, idle fill
// - Vocoder routing chosen by vocoder enable mask
// - Without new control, resend previous control values
// - Call end frame sent raises transmit done
// - Word 0 bits 5..4 carry block type
`ifndef FSK4_CFG_SVH
`define FSK4_CFG_SVH
// ==========================================================
// Register offsets
`define FSK4_REG_SETUP   8'ha1
`define FSK4_REG_MODE    8'hc1
`define FSK4_REG_RXW0    8'hb8
`define FSK4_REG_STATUS  8'hc9
`define FSK4_REG_AUX     8'hcc
`define FSK4_REG_TXW0    8'hb5
`define FSK4_REG_TXW1    8'hb6
`define FSK4_REG_OWN0    8'hd0
`define FSK4_OWN_COUNT   8'h06
`define FSK4_REG_ACCEPT  8'hd6
`define FSK4_REG_VOCODER 8'hd7
`define FSK4_REG_DROP    8'hd8
`define FSK4_REG_CS0     8'hd9
`define FSK4_REG_CS1     8'hda
`define FSK4_REG_CS2     8'hdb
// ==========================================================
// Mode values and setup bits
`define FSK4_MODE_IDLE   16'h0000
`define FSK4_MODE_RX     16'h0011
`define FSK4_MODE_TX     16'h0012
`define FSK4_OPEN_BIT    0
`define FSK4_SOFT_BIT    1
`define FSK4_PROTO_BIT   2
`define FSK4_PRE_BIT     11
// ==========================================================
// Block word fields
`define FSK4_ID_MSB      5
`define FSK4_ID_LSB      4
`define FSK4_INFO_MSB    15
`define FSK4_INFO_LSB    12
`define FSK4_BLK_PARAM   2'h0
`define FSK4_BLK_DATA    2'h1
`define FSK4_BLK_RI      2'h2
`define FSK4_BLK_SC_RI   2'h3
`define FSK4_RI_CS_BIT   15
`define FSK4_RI_CM_MSB   14
`define FSK4_RI_CM_LSB   13
`define FSK4_CODE_MASK1  9'h03f
`define FSK4_CODE_MASK2  9'h1ff
// ==========================================================
// Status codes and reset values
`define FSK4_ERR_NONE    16'h0000
`define FSK4_ERR_CTL     16'h0001
`define FSK4_ERR_DATA    16'h0002
`define FSK4_ERR_DROP    16'h0003
`define FSK4_ACCEPT_RST  16'hffff
`define FSK4_VOCODER_RST 16'h0002
`define FSK4_DROP_RST    8'h04
`endif

// >>> logic/fsk4_pkg.sv
// Types shared by the formatted frame codec files.
// Assumes fsk4_cfg.svh supplies all numeric constants.
package fsk4_pkg;
  // Receive call states
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_HUNT = 2'b01,
    RX_CTL  = 2'b10,
    RX_CALL = 2'b11
  } fsk4_rx_state_type;
  // Transmit frame sequencer states
  typedef enum logic [2:0] {
    TX_OFF  = 3'b000,
    TX_PRE  = 3'b001,
    TX_SYNC = 3'b010,
    TX_RI   = 3'b011,
    TX_SC   = 3'b100,
    TX_B1   = 3'b101,
    TX_B2   = 3'b110,
    TX_DONE = 3'b111
  } fsk4_tx_state_type;
  // Field kinds handed to the channel encoder
  typedef enum logic [2:0] {
    F_PRE   = 3'b000,
    F_SYNC  = 3'b001,
    F_RI    = 3'b010,
    F_SC    = 3'b011,
    F_PARAM = 3'b100,
    F_PAD   = 3'b101,
    F_TRAF  = 3'b110
  } fsk4_field_type;
endpackage

// >>> logic/fsk4_addr_match.sv
// Address matcher: compares a received code with stored own codes.
// Assumes codes arrive flattened, entry 0 in the low bits.
`timescale 1ns/1ps
module fsk4_addr_match #(
  parameter int W = 9,
  parameter int N = 6
) (
  input  wire logic [W-1:0]   code,
  input  wire logic [W-1:0]   code_mask,
  input  wire logic [N*W-1:0] own_codes,
  output logic                exact,
  output logic                all_call,
  output logic                match_any
);
  // ==========================================================
  // Per-entry compare
  logic [N-1:0] hit;      // One bit per own code
  logic [W-1:0] masked;   // Code limited to protocol width

  assign masked = code & code_mask;

  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_cmp
      // Masking both sides lets one store serve both widths
      assign hit[i] = ((own_codes[i*W +: W] & code_mask) == masked);
    end
  endgenerate

  // ==========================================================
  // Results
  assign exact     = |hit;
  assign all_call  = (masked == '0);
  assign match_any = exact | all_call;
endmodule

// >>> logic/fsk4_frame_codec.sv
// Formatted frame codec: receive call control and transmit framing.
// Assumes a decoder and encoder on the same clock around it, and a
// host register port; irq outputs are one-cycle pulses.
`timescale 1ns/1ps
`include "fsk4_cfg.svh"
module fsk4_frame_codec #(
  parameter logic [3:0] CALL_END_INFO = 4'hf
) (
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire logic                    reg_wr_en,
  input  wire logic                    reg_rd_en,
  input  wire logic [7:0]              reg_addr,
  input  wire logic [15:0]             reg_wr_data,
  output logic [15:0]                  reg_rd_data,
  output logic                         reg_rd_valid,
  input  wire logic                    sync_found,
  input  wire logic                    sync_second,
  input  wire logic                    ctl_valid,
  input  wire logic                    ctl_ok,
  input  wire logic [8:0]              ctl_code,
  input  wire logic [3:0]              ctl_info,
  input  wire logic                    ctl_end,
  input  wire logic                    blk_valid,
  input  wire logic [1:0]              blk_id,
  input  wire logic                    blk_ok,
  input  wire logic [9:0]              blk_data,
  input  wire logic                    sf_end,
  input  wire logic                    sf_bad,
  input  wire logic                    tx_field_ready,
  output logic                         tx_field_valid,
  output fsk4_pkg::fsk4_field_type     tx_field_kind,
  output logic [35:0]                  tx_field_data,
  output logic [1:0]                   tx_code_sel,
  output logic                         demod_en,
  output logic                         codec_en,
  output logic                         soft_mode,
  output logic                         first_sync_found_irq,
  output logic                         second_sync_found_irq,
  output logic                         called_irq,
  output logic                         data_ready_irq,
  output logic                         event_irq,
  output logic                         transmit_done_irq
);
  import fsk4_pkg::*;

  // ==========================================================
  // Host-visible registers
  logic [15:0] setup_reg;        // modem_setup_control
  logic [15:0] mode_reg;         // operating_mode_control
  logic [15:0] rxw0_reg;         // receive_block_word0
  logic [15:0] status_reg;       // modem_error_status
  logic [15:0] aux_reg;          // auxiliary_rx_info
  logic [15:0] txw1_reg;         // Transmit data staging word
  logic [8:0]  own_reg [6];      // Own codes
  logic [15:0] accept_reg;       // Call accept mask
  logic [15:0] voc_reg;          // Vocoder enable mask
  logic [7:0]  drop_reg;         // Corrupt superframe threshold
  logic [35:0] cs_reg;           // Stored call sign
  logic [15:0] rd_next;          // Read mux result

  // ==========================================================
  // Address decode
  logic [7:0] own_idx;           // Offset into own code store
  logic       wr_setup;
  logic       wr_mode;
  logic       wr_txw0;
  logic       wr_txw1;
  logic       wr_own;
  logic       wr_accept;
  logic       wr_voc;
  logic       wr_drop;
  logic       wr_cs0;
  logic       wr_cs1;
  logic       wr_cs2;

  assign own_idx   = reg_addr - `FSK4_REG_OWN0;
  assign wr_setup  = reg_wr_en && reg_addr == `FSK4_REG_SETUP;
  assign wr_mode   = reg_wr_en && reg_addr == `FSK4_REG_MODE;
  assign wr_txw0   = reg_wr_en && reg_addr == `FSK4_REG_TXW0;
  assign wr_txw1   = reg_wr_en && reg_addr == `FSK4_REG_TXW1;
  assign wr_own    = reg_wr_en && own_idx < `FSK4_OWN_COUNT;
  assign wr_accept = reg_wr_en && reg_addr == `FSK4_REG_ACCEPT;
  assign wr_voc    = reg_wr_en && reg_addr == `FSK4_REG_VOCODER;
  assign wr_drop   = reg_wr_en && reg_addr == `FSK4_REG_DROP;
  assign wr_cs0    = reg_wr_en && reg_addr == `FSK4_REG_CS0;
  assign wr_cs1    = reg_wr_en && reg_addr == `FSK4_REG_CS1;
  assign wr_cs2    = reg_wr_en && reg_addr == `FSK4_REG_CS2;

  // Mode and setup bits
  logic mode_rx;
  logic mode_tx;
  logic open_rx;
  logic proto2;
  assign mode_rx   = mode_reg == `FSK4_MODE_RX;
  assign mode_tx   = mode_reg == `FSK4_MODE_TX;
  assign open_rx   = setup_reg[`FSK4_OPEN_BIT];
  assign proto2    = setup_reg[`FSK4_PROTO_BIT];
  assign soft_mode = setup_reg[`FSK4_SOFT_BIT];

  // ==========================================================
  // Configuration writes; write-only registers read as zero
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      setup_reg  <= 16'h0000;
      mode_reg   <= `FSK4_MODE_IDLE;
      accept_reg <= `FSK4_ACCEPT_RST;
      voc_reg    <= `FSK4_VOCODER_RST;
      drop_reg   <= `FSK4_DROP_RST;
    end
    else
    begin
      if (wr_setup)  setup_reg  <= reg_wr_data;
      if (wr_mode)   mode_reg   <= reg_wr_data;
      if (wr_accept) accept_reg <= reg_wr_data;
      if (wr_voc)    voc_reg    <= reg_wr_data;
      if (wr_drop)   drop_reg   <= reg_wr_data[7:0];
    end
  end

  // Own codes and call sign; the host programs these once
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      for (int k = 0; k < 6; k++) own_reg[k] <= 9'h000;
      cs_reg <= 36'h0;
    end
    else
    begin
      if (wr_own) own_reg[own_idx[2:0]] <= reg_wr_data[8:0];
      if (wr_cs0) cs_reg[15:0]  <= reg_wr_data;
      if (wr_cs1) cs_reg[31:16] <= reg_wr_data;
      if (wr_cs2) cs_reg[35:32] <= reg_wr_data[3:0];
    end
  end

  // ==========================================================
  // Address match
  logic [53:0] own_flat;     // Own codes, entry 0 lowest
  logic [8:0]  code_mask;    // Six or nine bit codes
  logic        exact;
  logic        all_call;
  logic        match_any;

  genvar g;
  generate
    for (g = 0; g < 6; g++)
    begin : g_own
      assign own_flat[g*9 +: 9] = own_reg[g];
    end
  endgenerate

  assign code_mask = proto2 ? `FSK4_CODE_MASK2 : `FSK4_CODE_MASK1;

  fsk4_addr_match #(.W(9), .N(6)) u_match (
    .code      (ctl_code),
    .code_mask (code_mask),
    .own_codes (own_flat),
    .exact     (exact),
    .all_call  (all_call),
    .match_any (match_any)
  );

  // ==========================================================
  // Receive call control
  fsk4_rx_state_type rx_reg;
  fsk4_rx_state_type rx_next;
  logic [7:0] bad_reg;       // Consecutive corrupt superframes
  logic       accept;
  logic       take_ctl;
  logic       deliver;
  logic       drop_hit;
  logic       end_hit;
  logic       voc_rx_reg;    // Vocoder routed for this call

  // Type mask applies to the second protocol only
  assign accept   = match_any && (!proto2 || accept_reg[ctl_info]);
  assign take_ctl = rx_reg == RX_CTL && ctl_valid && ctl_ok;
  // Open receive also delivers before the call decision
  assign deliver  = blk_valid &&
                    (rx_reg == RX_CALL || (rx_reg == RX_CTL && open_rx));
  assign drop_hit = rx_reg == RX_CALL && sf_end && sf_bad &&
                    ({1'b0, bad_reg} + 9'h001 >= {1'b0, drop_reg});
  assign end_hit  = rx_reg == RX_CALL && ctl_valid && ctl_end;
  assign demod_en = rx_reg == RX_CTL || rx_reg == RX_CALL;

  // Next receive state
  always_comb
  begin
    rx_next = rx_reg;
    if (!mode_rx)
      rx_next = RX_IDLE;
    else
    begin
      unique case (rx_reg)
        RX_IDLE: rx_next = RX_HUNT;
        RX_HUNT: if (sync_found) rx_next = RX_CTL;
        RX_CTL:
          // Failed checks leave the state alone
          if (take_ctl)
            rx_next = (accept || open_rx) ? RX_CALL : RX_HUNT;
        RX_CALL: if (end_hit || drop_hit) rx_next = RX_HUNT;
      endcase
    end
  end

  // State, counter and vocoder routing
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rx_reg     <= RX_IDLE;
      bad_reg    <= 8'h00;
      voc_rx_reg <= 1'b0;
    end
    else
    begin
      rx_reg <= rx_next;
      if (take_ctl || rx_reg != RX_CALL)
        bad_reg <= 8'h00;
      else if (sf_end)
        bad_reg <= sf_bad ? bad_reg + 8'h01 : 8'h00;
      // Codec path is shut with the call
      if (take_ctl)
        voc_rx_reg <= voc_reg[ctl_info];
      else if (rx_next != RX_CALL)
        voc_rx_reg <= 1'b0;
    end
  end

  // Interrupt pulses and receive reports
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      first_sync_found_irq  <= 1'b0;
      second_sync_found_irq <= 1'b0;
      called_irq            <= 1'b0;
      data_ready_irq        <= 1'b0;
      event_irq             <= 1'b0;
      rxw0_reg              <= 16'h0000;
      status_reg            <= `FSK4_ERR_NONE;
      aux_reg               <= 16'h0000;
    end
    else
    begin
      first_sync_found_irq  <= rx_reg == RX_HUNT && mode_rx &&
                               sync_found && !sync_second;
      second_sync_found_irq <= rx_reg == RX_HUNT && mode_rx &&
                               sync_found && sync_second;
      called_irq     <= mode_rx && take_ctl && accept;
      data_ready_irq <= deliver;
      event_irq      <= (deliver && !blk_ok) || drop_hit;
      // Overwritten by each new block; host must keep up
      if (deliver)
        rxw0_reg <= {blk_data, blk_id, 2'b00, blk_ok, soft_mode};
      if (drop_hit)
        status_reg <= `FSK4_ERR_DROP;
      else if (deliver && !blk_ok)
        status_reg <= (blk_id == `FSK4_BLK_DATA) ?
                      `FSK4_ERR_DATA : `FSK4_ERR_CTL;
      if (take_ctl && accept)
        aux_reg <= {5'h00, all_call, exact, ctl_code};
    end
  end

  // ==========================================================
  // Transmit block store
  fsk4_tx_state_type tx_reg;
  fsk4_tx_state_type tx_next;
  logic [15:0] ri_reg;         // Radio info, kept across frames
  logic [25:0] sc_reg;         // Slow control, kept across frames
  logic [3:0]  info_reg;       // Information type of slow control
  logic [15:0] traf_reg [2];   // Two traffic blocks per frame
  logic [1:0]  traf_cnt_reg;   // Traffic blocks loaded
  logic [1:0]  w0_id;
  logic        load_traf;
  logic        fire;
  logic        frame_end;
  logic        sync_burst;
  logic        end_frame;

  assign w0_id      = reg_wr_data[`FSK4_ID_MSB:`FSK4_ID_LSB];
  assign load_traf  = wr_txw0 && w0_id == `FSK4_BLK_DATA &&
                      traf_cnt_reg != 2'h2;
  assign fire       = tx_field_valid && tx_field_ready;
  assign frame_end  = fire && tx_reg == TX_B2;
  assign sync_burst = !ri_reg[`FSK4_RI_CS_BIT];
  assign end_frame  = info_reg == CALL_END_INFO;

  // Block loads; stored control is resent if not reloaded
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      txw1_reg     <= 16'h0000;
      ri_reg       <= 16'h0000;
      sc_reg       <= 26'h0;
      info_reg     <= 4'h0;
      traf_reg[0]  <= 16'h0000;
      traf_reg[1]  <= 16'h0000;
      traf_cnt_reg <= 2'h0;
    end
    else
    begin
      if (wr_txw1) txw1_reg <= reg_wr_data;
      if (wr_txw0 && w0_id[1])
        ri_reg <= txw1_reg;
      if (wr_txw0 && w0_id == `FSK4_BLK_SC_RI)
      begin
        sc_reg   <= {reg_wr_data[15:6], txw1_reg};
        info_reg <= reg_wr_data[`FSK4_INFO_MSB:`FSK4_INFO_LSB];
      end
      // A load in the consuming cycle is kept for the next frame unless two blocks are already loaded
      if (load_traf)
        traf_reg[frame_end ? 1'b0 : traf_cnt_reg[0]] <= txw1_reg;
      if (frame_end)
        traf_cnt_reg <= load_traf ? 2'h1 : 2'h0;
      else if (load_traf)
        traf_cnt_reg <= traf_cnt_reg + 2'h1;
    end
  end

  // ==========================================================
  // Transmit frame sequencer
  always_comb
  begin
    tx_next = tx_reg;
    if (!mode_tx)
      tx_next = TX_OFF;
    else
    begin
      unique case (tx_reg)
        TX_OFF:  tx_next = setup_reg[`FSK4_PRE_BIT] ?
                           TX_PRE : TX_SYNC;
        TX_PRE:  if (fire) tx_next = TX_SYNC;
        TX_SYNC: if (fire) tx_next = TX_RI;
        TX_RI:   if (fire) tx_next = TX_SC;
        TX_SC:   if (fire) tx_next = TX_B1;
        TX_B1:   if (fire) tx_next = TX_B2;
        TX_B2:   if (fire) tx_next = end_frame ? TX_DONE : TX_SYNC;
        TX_DONE: tx_next = TX_DONE;
      endcase
    end
  end

  // Sequencer state and done pulse
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      tx_reg            <= TX_OFF;
      transmit_done_irq <= 1'b0;
    end
    else
    begin
      tx_reg            <= tx_next;
      transmit_done_irq <= frame_end && end_frame && mode_tx;
    end
  end

  // Field kind and contents for the channel encoder
  assign tx_field_valid = tx_reg != TX_OFF && tx_reg != TX_DONE;
  assign tx_field_kind  =
    tx_reg == TX_PRE  ? F_PRE  :
    tx_reg == TX_SYNC ? F_SYNC :
    tx_reg == TX_RI   ? F_RI   :
    tx_reg == TX_SC   ? F_SC   :
    tx_reg == TX_B1   ? (sync_burst ? F_PARAM : F_TRAF) :
                        (sync_burst ? F_PAD   : F_TRAF);
  assign tx_field_data  =
    tx_field_kind == F_RI    ? {20'h0, ri_reg}      :
    tx_field_kind == F_SC    ? {10'h0, sc_reg}      :
    tx_field_kind == F_PARAM ? cs_reg               :
    tx_field_kind == F_TRAF  ?
      {20'h0, traf_reg[tx_reg == TX_B2]}            :
                               36'h0;
  // Coding follows the communication mode of the radio info
  assign tx_code_sel = ri_reg[`FSK4_RI_CM_MSB:`FSK4_RI_CM_LSB];
  assign codec_en    = voc_rx_reg ||
                       (tx_field_valid && voc_reg[info_reg]);

  // ==========================================================
  // Register reads, one cycle after the strobe
  assign rd_next =
    reg_addr == `FSK4_REG_RXW0   ? rxw0_reg   :
    reg_addr == `FSK4_REG_STATUS ? status_reg :
    reg_addr == `FSK4_REG_AUX    ? aux_reg    : 16'h0000;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      reg_rd_data  <= 16'h0000;
      reg_rd_valid <= 1'b0;
    end
    else
    begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) reg_rd_data <= rd_next;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_sync_irq_hunt: assert property (
    rx_reg == RX_HUNT && mode_rx && sync_found |=>
    (first_sync_found_irq || second_sync_found_irq) && demod_en)
    else $error("sync irq or demod enable missing");
  a_ctl_fail_wait: assert property (
    rx_reg == RX_CTL && mode_rx && ctl_valid && !ctl_ok |=>
    rx_reg == RX_CTL && !called_irq)
    else $error("call decided on bad control");
  a_called_match: assert property (
    called_irq |-> $past(match_any))
    else $error("called without code match");
  a_reject_hunt: assert property (
    take_ctl && mode_rx && !accept && !open_rx |=> rx_reg == RX_HUNT)
    else $error("rejected call not back to hunt");
  a_called_aux: assert property (
    called_irq |-> aux_reg[8:0] == $past(ctl_code) && rx_reg == RX_CALL)
    else $error("aux report wrong after call");
  a_event_ready: assert property (
    deliver && !blk_ok && !drop_hit |=>
    event_irq && data_ready_irq && status_reg != `FSK4_ERR_NONE)
    else $error("check failure not flagged");
  a_end_hunt: assert property (
    end_hit && mode_rx |=> rx_reg == RX_HUNT ##1 !voc_rx_reg)
    else $error("end frame did not end call");
  a_drop_event: assert property (
    drop_hit |=> event_irq && status_reg == `FSK4_ERR_DROP)
    else $error("call drop not reported");
  a_open_deliver: assert property (
    blk_valid && open_rx && rx_reg == RX_CTL |=> data_ready_irq)
    else $error("open receive did not deliver");
  a_done_end: assert property (
    transmit_done_irq |-> $past(tx_reg) == TX_B2 && tx_reg == TX_DONE)
    else $error("transmit done out of place");
  a_param_cs: assert property (
    tx_field_valid && tx_reg == TX_B1 && sync_burst |->
    tx_field_kind == F_PARAM && tx_field_data == cs_reg)
    else $error("parameter block not call sign");

  c_call_taken: cover property (called_irq ##[1:20] data_ready_irq);
  c_call_drop:  cover property (drop_hit);
  c_tx_done:    cover property (transmit_done_irq);
endmodule

// >>> sim/fsk4_host_model.sv
// Host side of the codec: register writes and reads on the strobe port.
// Assumes strobes change at the falling edge of clock only.
`timescale 1ns/1ps
module fsk4_host_model (
  input  wire logic        clock,
  input  wire logic [15:0] reg_rd_data,
  input  wire logic        reg_rd_valid,
  output logic             reg_wr_en,
  output logic             reg_rd_en,
  output logic [7:0]       reg_addr,
  output logic [15:0]      reg_wr_data
);
  // ==========================================================
  // Idle bus at time zero
  initial
  begin
    reg_wr_en = 0;
    reg_rd_en = 0;
    reg_addr = 8'h00;
    reg_wr_data = 16'h0000;
  end
  // One write, then a quiet cycle so strobes never retrigger at once
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1;
    @(negedge clock);
    reg_wr_en = 0;
    reg_addr = ~a;
    reg_wr_data = ~d;
    @(negedge clock);
  endtask
  // Read is collected the cycle after the strobe, before any overwrite
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    d = 'x;
    reg_addr = a;
    reg_rd_en = 1;
    @(negedge clock);
    reg_rd_en = 0;
    reg_addr = ~a;
    if (reg_rd_valid === 1'b1)
      d = reg_rd_data;
    @(negedge clock);
  endtask
endmodule

// >>> sim/fsk4_frame_codec_tb.sv
// Self-checking bench for the frame codec: receive calls and transmit.
// Assumes the host model drives the register port.
`timescale 1ns/1ps
module fsk4_frame_codec_tb;
  import fsk4_pkg::*;
  logic clock, rst, reg_wr_en, reg_rd_en, reg_rd_valid;
  logic [7:0] reg_addr;
  logic [15:0] reg_wr_data, reg_rd_data, v;
  logic sync_found, sync_second, ctl_valid, ctl_ok, ctl_end, blk_valid;
  logic blk_ok, sf_end, sf_bad, tx_field_ready, tx_field_valid, demod_en;
  logic [8:0] ctl_code;
  logic [3:0] ctl_info;
  logic [1:0] blk_id, tx_code_sel;
  logic [9:0] blk_data;
  fsk4_field_type tx_field_kind;
  logic [35:0] tx_field_data;
  logic codec_en, soft_mode, first_sync_found_irq, second_sync_found_irq;
  logic called_irq, data_ready_irq, event_irq, transmit_done_irq;
  int failures = 0;
  int check_count = 0;
  fsk4_frame_codec i_dut (.clock, .rst, .reg_wr_en, .reg_rd_en, .reg_addr,
    .reg_wr_data, .reg_rd_data, .reg_rd_valid, .sync_found, .sync_second,
    .ctl_valid, .ctl_ok, .ctl_code, .ctl_info, .ctl_end, .blk_valid,
    .blk_id, .blk_ok, .blk_data, .sf_end, .sf_bad, .tx_field_ready,
    .tx_field_valid, .tx_field_kind, .tx_field_data, .tx_code_sel,
    .demod_en, .codec_en, .soft_mode, .first_sync_found_irq,
    .second_sync_found_irq, .called_irq, .data_ready_irq, .event_irq,
    .transmit_done_irq);
  fsk4_host_model i_host (.clock, .reg_rd_data, .reg_rd_valid, .reg_wr_en,
    .reg_rd_en, .reg_addr, .reg_wr_data);
  // ==========================================================
  // 125 MHz clock
  initial
  begin
    clock = 0;
    forever #4 clock = ~clock;
  end
  task step;
    @(negedge clock);
  endtask
  task chk(input logic [51:0] got, input logic [51:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Control fields of one frame, pulsed for a cycle
  task ctl(input logic ok, input logic [8:0] c);
    ctl_ok = ok;
    ctl_code = c;
    ctl_valid = 1;
    step;
    ctl_valid = 0;
  endtask
  task hunt;
    sync_found = 1;
    step;
    sync_found = 0;
  endtask
  task print_verdict;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    rst = 1;
    {sync_found, sync_second, ctl_valid, ctl_ok, ctl_end, blk_valid} = 0;
    {blk_ok, sf_end, sf_bad, tx_field_ready} = 0;
    {ctl_code, ctl_info, blk_id, blk_data} = 0;
    repeat (12) step;
    rst = 0;
    i_host.rd(8'hc9, v); chk(v, 0);
    i_host.wr(8'hc1, 16'h0011);
    hunt; chk({first_sync_found_irq, demod_en}, 2'b11);
    ctl(0, 9'h000); chk({called_irq, demod_en}, 2'b01);
    ctl(1, 9'h000); chk(called_irq, 1);
    i_host.rd(8'hcc, v); chk(v, 16'h0600);
    blk_id = 2'h1; blk_data = 10'h2a5; blk_valid = 1; step; blk_valid = 0;
    chk({data_ready_irq, event_irq}, 2'b11);
    i_host.rd(8'hb8, v); chk(v, {10'h2a5, 2'h1, 4'h0});
    i_host.rd(8'hc9, v); chk(v, 2);
    ctl_end = 1; ctl(1, 9'h000); ctl_end = 0; chk(demod_en, 0);
    hunt; ctl(1, 9'h015); chk(demod_en, 0);
    i_host.wr(8'hd0, 16'h0015);
    sync_second = 1; hunt; sync_second = 0;
    chk(second_sync_found_irq, 1);
    ctl(1, 9'h015); chk(called_irq, 1);
    i_host.rd(8'hcc, v); chk(v, 16'h0215);
    i_host.wr(8'hd8, 16'h0001);
    sf_end = 1; sf_bad = 1; step; sf_end = 0; sf_bad = 0;
    chk({event_irq, demod_en}, 2'b10);
    i_host.rd(8'hc9, v); chk(v, 3);
    // Nine-bit codes: only the wider compare tells 115 from 015
    i_host.wr(8'ha1, 16'h0004);
    hunt; ctl(1, 9'h115); chk(demod_en, 0);
    i_host.wr(8'ha1, 16'h0003);
    hunt; blk_ok = 1; blk_valid = 1; step; blk_valid = 0;
    chk(data_ready_irq, 1);
    ctl(1, 9'h033); chk({called_irq, demod_en}, 2'b01);
    blk_valid = 1; step; blk_valid = 0;
    chk({data_ready_irq, event_irq}, 2'b10);
    i_host.rd(8'hb8, v);
    chk({soft_mode, v}, {1'b1, 10'h2a5, 6'h13});
    i_host.wr(8'hc1, 16'h0000); step; chk(demod_en, 0);
    // Transmit: sync-burst frame carries the stored call sign
    i_host.wr(8'ha1, 16'h0000);
    i_host.wr(8'hd9, 16'h1234);
    i_host.wr(8'hb6, 16'h0000);
    i_host.wr(8'hb5, 16'h0020);
    tx_field_ready = 1;
    i_host.wr(8'hc1, 16'h0012);
    for (int i = 0; i < 8 && tx_field_valid !== 1'b1; i++) step;
    chk({tx_field_valid, tx_field_kind}, {1'b1, F_SYNC}); step;
    chk(tx_field_kind, F_RI); step;
    chk(tx_field_kind, F_SC); step;
    chk({tx_field_kind, tx_field_data}, {F_PARAM, 36'h1234}); step;
    chk(tx_field_kind, F_PAD); step;
    // Hold at the next sync field while a service frame is loaded
    tx_field_ready = 0;
    i_host.wr(8'hb6, 16'hc000);
    i_host.wr(8'hb5, 16'hf030);
    i_host.wr(8'hb6, 16'habcd);
    i_host.wr(8'hb5, 16'h0010);
    i_host.wr(8'hb6, 16'h1357);
    i_host.wr(8'hb5, 16'h0010);
    chk({tx_code_sel, codec_en}, 3'b100);
    tx_field_ready = 1;
    repeat (3) step;
    chk({tx_field_kind, tx_field_data}, {F_TRAF, 36'habcd});
    step;
    chk({tx_field_kind, tx_field_data}, {F_TRAF, 36'h1357});
    for (int i = 0; i < 20 && transmit_done_irq !== 1'b1; i++) step;
    chk(transmit_done_irq, 1);
    print_verdict;
  end
endmodule
